// ==== sys_cfg_consts.vh ====
// Constants for the system configuration control register bank.
`ifndef SYS_CFG_CONSTS_VH
`define SYS_CFG_CONSTS_VH

// Register byte offsets.
`define OFS_CTRL        5'h00
`define OFS_CTRL_SET    5'h04
`define OFS_CTRL_CLR    5'h08
`define OFS_CTRL_INV    5'h0C
`define OFS_UNLOCK      5'h10
`define OFS_STATUS      5'h14

// Access size codes on the size port.
`define SIZE_BYTE       2'h0
`define SIZE_HALF       2'h1
`define SIZE_WORD       2'h2

// Alias operations.
`define OP_WRITE        2'h0
`define OP_SET          2'h1
`define OP_CLR          2'h2
`define OP_INV          2'h3

// Field positions of the control byte.
`define BIT_PUMP        7
`define BIT_RSVD_HI     6
`define BIT_ECC_HI      5
`define BIT_ECC_LO      4
`define BIT_DEBUG       3
`define BIT_TRACE       2
`define BIT_RSVD_LO     1
`define BIT_TDO         0

// Flash error-correction mode encodings.
`define ECC_FULL        2'h0
`define ECC_DYNAMIC     2'h1
`define ECC_OFF_LOCKED  2'h2
`define ECC_OFF_OPEN    2'h3

// Implemented bits of the control byte.
`define CTRL_MASK       8'hBD

// Reset value of the control byte: mode open, debug port on.
`define CTRL_RESET      8'h38

// Status bits.
`define BIT_ST_UNLOCKED 0
`define BIT_ST_REFUSED  1
`define BIT_ST_ECC_LOCK 2

// Unlock keys; the values are arbitrary.
`define UNLOCK_KEY1     32'h1234ABCD
`define UNLOCK_KEY2     32'hCDAB4321

// Trace clock half period in system clock cycles.
`define TRACE_HALF_DIV  4

`endif

// ==== unlock_seq.v ====
// Two-key unlock sequence that opens writes to the protected bit.
`timescale 1ns/10ps
`include "sys_cfg_consts.vh"

module unlock_seq (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        key_wr,
    input  wire [31:0] key_data,
    output reg         unlocked_q
);

    reg key1_seen_q;

    // The second key must come in the very next key write, else the
    // sequence starts over; any other key value locks again.
    always @(posedge clk) begin
        if (rst) begin
            key1_seen_q <= 1'b0;
            unlocked_q  <= 1'b0;
        end else if (ce && key_wr) begin
            key1_seen_q <= (key_data == `UNLOCK_KEY1);
            if (key1_seen_q && key_data == `UNLOCK_KEY2) begin
                unlocked_q <= 1'b1;
            end else if (key_data != `UNLOCK_KEY1) begin
                unlocked_q <= 1'b0;
            end
        end
    end

endmodule

// ==== trace_clk_gen.v ====
// Trace clock divider that runs only while tracing is enabled.
`timescale 1ns/10ps
`include "sys_cfg_consts.vh"

module trace_clk_gen #(
    parameter HALF_DIV = `TRACE_HALF_DIV
) (
    input  wire clk,
    input  wire rst,
    input  wire ce,
    input  wire run,
    output reg  trace_clk_q
);

    reg [7:0] cnt_q;

    // Stopping parks the clock low so the probe sees a clean edge later.
    always @(posedge clk) begin
        if (rst) begin
            cnt_q       <= 8'h00;
            trace_clk_q <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_q       <= 8'h00;
                trace_clk_q <= 1'b0;
            end else if (cnt_q == HALF_DIV[7:0] - 8'h01) begin
                cnt_q       <= 8'h00;
                trace_clk_q <= ~trace_clk_q;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end

endmodule

// ==== system_config_control_reg.v ====
// System configuration control register with set, clear, invert aliases.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/10ps
`include "sys_cfg_consts.vh"

// Summary of operation
// - Half-word and word accesses work on the register and all aliases.
// - Byte accesses are ignored completely, no change and no effect.
// - Mode 11 disables ECC and dynamic ECC; field stays writable.
// - Mode 10 disables ECC and dynamic ECC; field locks.
// - Mode 01 enables dynamic ECC; field locks.
// - Mode 00 enables full ECC, locks field, disables word programming.
// - Bit 3 enables the boundary-scan debug port.
// - Bit 2 enables trace outputs and runs the trace clock.
// - Bit 0 makes two-wire debug use the data-out pin.
// - Bit 7 turns the analog I/O charge pump on.
// - Bits 6 and 1 are unimplemented and read zero.
// - The protected bit changes only after the unlock sequence.
module system_config_control_reg #(
    parameter TRACE_HALF_DIV = `TRACE_HALF_DIV
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire [4:0]  addr,
    input  wire [1:0]  size,
    input  wire [31:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [31:0] rdata,
    output reg         analog_io_pump_enable,
    output reg         ecc_enable,
    output reg         dynamic_ecc_enable,
    output reg         word_program_disable,
    output reg         debug_port_enable,
    output reg         trace_output_enable,
    output wire        trace_clk,
    output reg         two_wire_dataout_enable
);

    reg  [7:0]  ctrl_q;
    reg  [7:0]  ctrl_d;
    reg         refused_q;
    reg         refused_d;
    wire        unlocked;
    wire        size_ok;
    wire        low_byte_hit;
    wire        aligned;
    wire        ctrl_sel;
    wire [1:0]  op;
    wire [7:0]  wbyte;
    wire        key_wr;
    wire        status_wr;
    wire        ecc_locked;
    reg  [31:0] rdata_d;

    // Applies one alias operation to the stored byte.
    function [7:0] apply_op;
        input [1:0] o;
        input [7:0] old;
        input [7:0] d;
        begin
            case (o)
                `OP_WRITE: apply_op = d;
                `OP_SET:   apply_op = old | d;
                `OP_CLR:   apply_op = old & ~d;
                `OP_INV:   apply_op = old ^ d;
                default:   apply_op = old;
            endcase
        end
    endfunction

    // Builds the value shown on a read of the control register.
    function [31:0] ctrl_view;
        input [7:0] c;
        begin
            ctrl_view = {24'h000000, c & `CTRL_MASK};
        end
    endfunction

    // Only half-word and word sizes reach the register file; a byte
    // access is dropped before decode so it cannot touch any state.
    assign size_ok = (size == `SIZE_HALF) || (size == `SIZE_WORD);

    // A word must be word aligned and a half-word half aligned.
    assign aligned = (size == `SIZE_WORD) ? (addr[1:0] == 2'h0)
                                          : (addr[0] == 1'b0);

    // Only the low half-word carries implemented bits.
    assign low_byte_hit = (addr[1] == 1'b0);

    assign ctrl_sel = size_ok && aligned &&
                      (addr[4:2] <= `OFS_CTRL_INV >> 2);

    assign op = addr[3:2];

    assign wbyte = wdata[7:0];

    assign key_wr = ce && wr && (size == `SIZE_WORD) &&
                    (addr == `OFS_UNLOCK);

    assign status_wr = ce && wr && size_ok && aligned &&
                       (addr[4:2] == `OFS_STATUS >> 2) && low_byte_hit;

    // Any mode other than the open one holds the field fixed.
    assign ecc_locked = (ctrl_q[`BIT_ECC_HI:`BIT_ECC_LO] !=
                         `ECC_OFF_OPEN);

    unlock_seq u_unlock (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .key_wr     (key_wr),
        .key_data   (wdata),
        .unlocked_q (unlocked)
    );

    trace_clk_gen #(
        .HALF_DIV    (TRACE_HALF_DIV)
    ) u_trace_clk (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .run         (ctrl_q[`BIT_TRACE]),
        .trace_clk_q (trace_clk)
    );

    // Next value of the control byte.
    always @* begin
        ctrl_d    = ctrl_q;
        refused_d = refused_q;
        // Writing a one to the sticky refusal flag clears it. The refusal
        // set below comes later in this process, so a set always wins.
        if (status_wr && wdata[`BIT_ST_REFUSED]) begin
            refused_d = 1'b0;
        end
        if (ce && wr && ctrl_sel && low_byte_hit) begin
            ctrl_d = apply_op(op, ctrl_q, wbyte);
            // Unimplemented bits never hold a one.
            ctrl_d[`BIT_RSVD_HI] = 1'b0;
            ctrl_d[`BIT_RSVD_LO] = 1'b0;
            // Once the mode has left 11 only a reset can change it again.
            if (ecc_locked) begin
                ctrl_d[`BIT_ECC_HI:`BIT_ECC_LO] =
                    ctrl_q[`BIT_ECC_HI:`BIT_ECC_LO];
            end
            // Without the unlock sequence the protected bit is kept
            // and the refused attempt is remembered.
            if (!unlocked &&
                ctrl_d[`BIT_PUMP] != ctrl_q[`BIT_PUMP]) begin
                ctrl_d[`BIT_PUMP] = ctrl_q[`BIT_PUMP];
                refused_d = 1'b1;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            ctrl_q    <= `CTRL_RESET;
            refused_q <= 1'b0;
        end else if (ce) begin
            ctrl_q    <= ctrl_d;
            refused_q <= refused_d;
        end
    end

    // Read mux; a byte read, a misaligned read or an unmapped address
    // answers zero.
    always @* begin
        rdata_d = 32'h00000000;
        if (size_ok && aligned && low_byte_hit) begin
            case (addr[4:2])
                3'h0: rdata_d = ctrl_view(ctrl_q);
                3'h1: rdata_d = ctrl_view(ctrl_q);
                3'h2: rdata_d = ctrl_view(ctrl_q);
                3'h3: rdata_d = ctrl_view(ctrl_q);
                3'h5: begin
                    rdata_d[`BIT_ST_UNLOCKED] = unlocked;
                    rdata_d[`BIT_ST_REFUSED]  = refused_q;
                    rdata_d[`BIT_ST_ECC_LOCK] = ecc_locked;
                end
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            if (rd) begin
                rdata <= rdata_d;
            end else begin
                rdata <= 32'h00000000;
            end
        end
    end

    // Control outputs, registered from the stored byte so they change
    // one cycle after the register.
    always @(posedge clk) begin
        if (rst) begin
            analog_io_pump_enable   <= 1'b0;
            ecc_enable              <= 1'b0;
            dynamic_ecc_enable      <= 1'b0;
            word_program_disable    <= 1'b0;
            debug_port_enable       <= 1'b0;
            trace_output_enable     <= 1'b0;
            two_wire_dataout_enable <= 1'b0;
        end else if (ce) begin
            analog_io_pump_enable <= ctrl_q[`BIT_PUMP];
            debug_port_enable     <= ctrl_q[`BIT_DEBUG];
            trace_output_enable   <= ctrl_q[`BIT_TRACE];
            two_wire_dataout_enable <= ctrl_q[`BIT_TDO];
            case (ctrl_q[`BIT_ECC_HI:`BIT_ECC_LO])
                `ECC_FULL: begin
                    ecc_enable           <= 1'b1;
                    dynamic_ecc_enable   <= 1'b0;
                    word_program_disable <= 1'b1;
                end
                `ECC_DYNAMIC: begin
                    ecc_enable           <= 1'b0;
                    dynamic_ecc_enable   <= 1'b1;
                    word_program_disable <= 1'b0;
                end
                `ECC_OFF_LOCKED: begin
                    ecc_enable           <= 1'b0;
                    dynamic_ecc_enable   <= 1'b0;
                    word_program_disable <= 1'b0;
                end
                default: begin
                    ecc_enable           <= 1'b0;
                    dynamic_ecc_enable   <= 1'b0;
                    word_program_disable <= 1'b0;
                end
            endcase
        end
    end

endmodule

// ==== cfg_ctrl_monitor.sv ====
// Port-level assertions for the configuration control register.
`timescale 1ns/10ps
`include "sys_cfg_consts.vh"
module cfg_ctrl_monitor #(
    parameter TRACE_HALF_DIV = 4
) (
    input logic        clk,
    input logic        rst,
    input logic        ce,
    input logic [4:0]  addr,
    input logic [1:0]  size,
    input logic [31:0] wdata,
    input logic        wr,
    input logic        rd,
    input logic [31:0] rdata,
    input logic        analog_io_pump_enable,
    input logic        ecc_enable,
    input logic        dynamic_ecc_enable,
    input logic        word_program_disable,
    input logic        debug_port_enable,
    input logic        trace_output_enable,
    input logic        trace_clk,
    input logic        two_wire_dataout_enable
);
    // A write reaches the register at the next edge and the outputs one
    // edge later, so its effect is first sampled two edges after it.
    wire [5:0] outs = {analog_io_pump_enable, ecc_enable,
                       dynamic_ecc_enable, debug_port_enable,
                       trace_output_enable, two_wire_dataout_enable};
    wire       wr_w = ce && wr && size == `SIZE_WORD;
    wire       rd_c = ce && rd && addr == `OFS_CTRL;
    wire       w3   = wdata[3];
    wire       w0   = wdata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    byte_ignore_a: assert property (ce && wr && size == `SIZE_BYTE
        |-> ##2 $stable(outs))
        else $error("byte write changed an output");
    rsvd_zero_a: assert property (rd_c |-> ##1
        rdata[6] == 1'b0 && rdata[1] == 1'b0)
        else $error("unimplemented bit read as one");
    ecc_excl_a: assert property (!(ecc_enable && dynamic_ecc_enable))
        else $error("full and dynamic correction both on");
    ecc_wpd_a: assert property (ecc_enable == word_program_disable)
        else $error("word program disable differs from full correction");
    // A reset legally reopens the mode, so its edge starts no attempt.
    ecc_lock_a: assert property (!rst &&
        (ecc_enable || dynamic_ecc_enable) |=> $stable(outs[4:3]))
        else $error("locked correction mode changed");
    trace_stop_a: assert property (!trace_output_enable [*3]
        |-> !trace_clk)
        else $error("trace clock runs while tracing is off");
    ctrl_write_a: assert property (wr_w && addr == `OFS_CTRL |-> ##2
        debug_port_enable == $past(w3, 2) &&
        two_wire_dataout_enable == $past(w0, 2))
        else $error("direct write not reflected on outputs");
    set_alias_a: assert property (wr_w && addr == `OFS_CTRL_SET &&
        wdata[2] |-> ##2 trace_output_enable)
        else $error("set alias did not set the trace bit");
    inv_alias_a: assert property (wr_w && addr == `OFS_CTRL_INV &&
        wdata[3] |-> ##2 debug_port_enable != $past(debug_port_enable))
        else $error("invert alias did not toggle the debug bit");
endmodule
bind system_config_control_reg cfg_ctrl_monitor #(
    .TRACE_HALF_DIV(TRACE_HALF_DIV)
) cfg_ctrl_monitor_inst (
    .clk                     (clk),
    .rst                     (rst),
    .ce                      (ce),
    .addr                    (addr),
    .size                    (size),
    .wdata                   (wdata),
    .wr                      (wr),
    .rd                      (rd),
    .rdata                   (rdata),
    .analog_io_pump_enable   (analog_io_pump_enable),
    .ecc_enable              (ecc_enable),
    .dynamic_ecc_enable      (dynamic_ecc_enable),
    .word_program_disable    (word_program_disable),
    .debug_port_enable       (debug_port_enable),
    .trace_output_enable     (trace_output_enable),
    .trace_clk               (trace_clk),
    .two_wire_dataout_enable (two_wire_dataout_enable)
);

// ==== system_config_control_reg_bench.sv ====
// Self-checking bench for the configuration control register.
`timescale 1ns/10ps
`include "sys_cfg_consts.vh"
module system_config_control_reg_bench;
    localparam HD = 4;
    reg         clk = 0;
    reg         rst = 1;
    reg         ce = 1;
    reg  [4:0]  addr = 0;
    reg  [1:0]  size = 0;
    reg  [31:0] wdata = 0;
    reg         wr = 0;
    reg         rd = 0;
    wire [31:0] rdata;
    wire        pump, ecc, dyn, wpd, dbg, trc, tclk, tdo;
    integer     err_count = 0;
    integer     check_count = 0;
    integer     cycles = 0;
    integer     seed = 26;
    integer     i, n, op;
    reg  [31:0] exp_q[$];
    reg  [7:0]  ctrl, r;
    reg         pend = 0;
    reg         last;
    always #5 clk = ~clk;
    system_config_control_reg #(
        .TRACE_HALF_DIV(HD)
    ) system_config_control_reg_inst (
        .clk(clk), .rst(rst), .ce(ce), .addr(addr), .size(size),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .analog_io_pump_enable(pump), .ecc_enable(ecc),
        .dynamic_ecc_enable(dyn), .word_program_disable(wpd),
        .debug_port_enable(dbg), .trace_output_enable(trc),
        .trace_clk(tclk), .two_wire_dataout_enable(tdo));
    task chk(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: got %h expected %h",
                         $time, got, exp);
            end
        end
    endtask
    task bus(input w, input rq, input [4:0] a, input [1:0] s,
             input [31:0] d);
        begin
            @(posedge clk);
            wr <= w;
            rd <= rq;
            addr <= a;
            size <= s;
            wdata <= d;
        end
    endtask
    // The expected read value is queued before the strobe goes out.
    task rdx(input [4:0] a, input [31:0] x);
        begin
            exp_q.push_back(x);
            bus(0, 1, a, `SIZE_WORD, 32'h0);
        end
    endtask
    task idle(input integer k);
        begin
            bus(0, 0, 5'h00, `SIZE_WORD, 32'h0);
            repeat (k) @(posedge clk);
            @(negedge clk);
        end
    endtask
    task outs(input [7:0] c);
        chk({25'h0, pump, ecc, dyn, wpd, dbg, trc, tdo},
            {25'h0, c[7], c[5:4] == 2'h0, c[5:4] == 2'h1,
             c[5:4] == 2'h0, c[3], c[2], c[0]});
    endtask
    task final_report;
        begin
            $display("checks %0d, mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    always @(posedge clk) pend <= rd && ce;
    always @(negedge clk) begin
        if (pend && exp_q.size() > 0)
            chk(rdata, exp_q.pop_front());
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            final_report;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 0;
        rdx(`OFS_CTRL, 32'h38);
        idle(3);
        outs(8'h38);
        $display("test reset done");
        // A trace probe is taken to be attached from here on.
        bus(1, 0, `OFS_CTRL, `SIZE_WORD, 32'h3F);
        rdx(`OFS_CTRL, 32'h3D);
        idle(3);
        outs(8'h3D);
        n = 0;
        last = tclk;
        for (i = 0; i < 40; i = i + 1) begin
            @(negedge clk);
            if (tclk !== last) n = n + 1;
            last = tclk;
        end
        chk(n, 40 / HD);
        bus(1, 0, `OFS_CTRL_CLR, `SIZE_HALF, 32'h4);
        idle(4);
        chk({31'h0, tclk}, 32'h0);
        outs(8'h39);
        $display("test trace done");
        bus(1, 0, `OFS_CTRL, `SIZE_BYTE, 32'h0);
        bus(1, 0, `OFS_CTRL_INV, `SIZE_BYTE, 32'hD);
        bus(1, 0, `OFS_CTRL, 2'h3, 32'h0);
        bus(1, 0, 5'h02, `SIZE_HALF, 32'hFFFF);
        rdx(`OFS_CTRL, 32'h39);
        rdx(5'h18, 32'h0);
        idle(3);
        outs(8'h39);
        $display("test ignored access done");
        ctrl = 8'h39;
        for (i = 0; i < 12; i = i + 1) begin
            r = $random(seed) & 8'h0D;
            op = i % 3;
            bus(1, 0, `OFS_CTRL_SET + 5'(4 * op),
                i[0] ? `SIZE_HALF : `SIZE_WORD, {24'h0, r});
            ctrl = op == 0 ? ctrl | r : op == 1 ? ctrl & ~r : ctrl ^ r;
            rdx(`OFS_CTRL, {24'h0, ctrl});
        end
        idle(3);
        outs(ctrl);
        $display("test aliases done");
        bus(1, 0, `OFS_CTRL_SET, `SIZE_WORD, 32'h80);
        rdx(`OFS_CTRL, {24'h0, ctrl});
        rdx(`OFS_STATUS, 32'h2);
        bus(1, 0, `OFS_UNLOCK, `SIZE_WORD, `UNLOCK_KEY1);
        bus(1, 0, `OFS_UNLOCK, `SIZE_WORD, `UNLOCK_KEY2);
        bus(1, 0, `OFS_CTRL_SET, `SIZE_WORD, 32'h80);
        rdx(`OFS_STATUS, 32'h3);
        bus(1, 0, `OFS_STATUS, `SIZE_WORD, 32'h2);
        rdx(`OFS_STATUS, 32'h1);
        idle(3);
        outs(ctrl | 8'h80);
        // With the clock enable low a legal, unlocked write must not land.
        @(posedge clk);
        ce <= 1'b0;
        bus(1, 0, `OFS_CTRL_CLR, `SIZE_WORD, 32'h8D);
        idle(2);
        outs(ctrl | 8'h80);
        @(posedge clk);
        ce <= 1'b1;
        rdx(`OFS_CTRL, {24'h0, ctrl | 8'h80});
        idle(1);
        $display("test unlock done");
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge clk);
            rst <= 1;
            @(posedge clk);
            rst <= 0;
            r = {2'b00, i[1:0], 4'h8};
            bus(1, 0, `OFS_CTRL, `SIZE_WORD, {24'h0, r});
            bus(1, 0, `OFS_CTRL, `SIZE_WORD, 32'h38);
            rdx(`OFS_CTRL, {24'h0, r});
            rdx(`OFS_STATUS, 32'h4);
            idle(3);
            outs(r);
        end
        $display("test ecc modes done");
        final_report;
    end
endmodule
